// [src/lia_intr_agg.sv]
// interrupt aggregation for a multi-channel line interface unit
// assumes same-clock event and status inputs and a classic wishbone master
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "lia_regs.svh"

// Summary of operation
// - nineteen per-channel sources plus one global
// - sources one to ten pend on status edges
// - sources eleven to twenty pend directly
// - individual masks plus global mask bit one
// - any unmasked pending drives interrupt pin
// - unmasked channel pending sets summary bit
// - host writes one to clear pending
// - summary holds until channel fully acknowledged or masked
// - pin releases only when all acknowledged or masked
// - paired sources share edge select bits
// - pattern sync uses bit five throughout
// - inband activate bit one, deactivate bit zero
// - jitter buffer faults pend bits five, six
// - error counter overflow pends bit zero
// - pattern error pends bit one, mask one
// - one second tick pends timer bit zero
// - resets mask all or one channel
// - channel reset keeps line standard bit
// - channel reset self-clears within one microsecond
module lia_intr_agg #(
  parameter int unsigned SECOND_CYCLES = `LIA_SECOND_CYCLES
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [15:0]                 wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // live status levels per channel
  input  wire logic [`LIA_NUM_CH*5-1:0]    live_status_reg0_i,
  input  wire logic [`LIA_NUM_CH*8-1:0]    live_status_reg1_i,
  // direct event pulses per channel
  input  wire logic [`LIA_NUM_CH*3-1:0]    pend0_evt_i,
  input  wire logic [`LIA_NUM_CH*6-1:0]    pend2_evt_i,
  // interrupt pin, open drain
  output logic                             int_n_o,
  output logic                             int_n_oe_o,
  // summaries and channel mode
  output logic [`LIA_NUM_CH-1:0]           channel_summary_o,
  output logic [`LIA_NUM_CH-1:0]           line_standard_o
);
  localparam int NCH = `LIA_NUM_CH;

  // per-channel state
  lia_pkg::lia_byte_type     edge_q  [NCH];
  lia_pkg::lia_byte_type     edge_d  [NCH];
  lia_pkg::lia_byte_type     pend0_q [NCH];
  lia_pkg::lia_byte_type     pend0_d [NCH];
  lia_pkg::lia_byte_type     pend1_q [NCH];
  lia_pkg::lia_byte_type     pend1_d [NCH];
  lia_pkg::lia_byte_type     pend2_q [NCH];
  lia_pkg::lia_byte_type     pend2_d [NCH];
  lia_pkg::lia_byte_type     mask0_q [NCH];
  lia_pkg::lia_byte_type     mask0_d [NCH];
  lia_pkg::lia_byte_type     mask1_q [NCH];
  lia_pkg::lia_byte_type     mask1_d [NCH];
  lia_pkg::lia_byte_type     mask2_q [NCH];
  lia_pkg::lia_byte_type     mask2_d [NCH];
  logic [4:0]                prv0_q  [NCH];
  logic [4:0]                prv0_d  [NCH];
  lia_pkg::lia_byte_type     prv1_q  [NCH];
  lia_pkg::lia_byte_type     prv1_d  [NCH];
  lia_pkg::lia_srst_cnt_type srst_q  [NCH];
  lia_pkg::lia_srst_cnt_type srst_d  [NCH];
  logic [NCH-1:0]            std_q;
  logic [NCH-1:0]            std_d;
  logic [NCH-1:0]            busy;
  logic [NCH-1:0]            chan_act;
  logic [NCH-1:0]            wr_ch;

  // global state
  lia_pkg::lia_byte_type     gcf_q;
  lia_pkg::lia_byte_type     gcf_d;
  logic                      tmr_pend_q;
  logic                      tmr_pend_d;
  lia_pkg::lia_tick_cnt_type tick_cnt_q;
  lia_pkg::lia_tick_cnt_type tick_cnt_d;
  logic                      tick;
  logic                      glb_masked;
  logic                      any_act;
  logic                      ack_q;
  logic                      ack_d;
  logic [31:0]               rdat_q;
  logic [31:0]               rdat_d;
  logic [NCH-1:0]            sum_q;
  logic                      irq_q;

  // bus decode
  logic                      req;
  logic                      wr_hit;
  lia_pkg::lia_slot_type     slot;
  lia_pkg::lia_slot_type     ch_sel;
  logic                      ch_ok;
  logic                      glb_ok;
  logic [3:0]                idx;
  lia_pkg::lia_byte_type     wdat;

  assign req    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_hit = req && wb_we_i && wb_sel_i[0];
  assign slot   = wb_adr_i[10:6];
  assign ch_sel = slot - `LIA_CH_FIRST_SLOT;
  assign idx    = wb_adr_i[5:2];
  assign wdat   = wb_dat_i[7:0];
  assign ch_ok  = (wb_adr_i[15:11] == `LIA_ADR_TOP_ZERO) && (slot >= `LIA_CH_FIRST_SLOT)
                  && (ch_sel < 5'(NCH));
  assign glb_ok = (wb_adr_i[15:11] == `LIA_ADR_TOP_ZERO) && (slot == 5'h00);
  assign glb_masked = gcf_q[`LIA_GCF_GLB_MASK];

  // per-channel source logic
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [4:0] s0;
    logic [7:0] s1;
    logic [4:0] ies0;
    logic [7:0] ies1;
    logic [4:0] edg0;
    logic [7:0] edg1;
    assign s0     = live_status_reg0_i[c*5 +: 5];
    assign s1     = live_status_reg1_i[c*8 +: 8] & `LIA_PEND1_USED;
    assign wr_ch[c] = wr_hit && ch_ok && (ch_sel == 5'(c));
    assign busy[c]  = (srst_q[c] != '0);
    // shared edge selects: loss pair on b1, alarm pair on b6, inband pair on b0
    assign ies0 = {edge_q[c][4], edge_q[c][3], edge_q[c][2], edge_q[c][1], edge_q[c][1]};
    assign ies1 = {edge_q[c][6], edge_q[c][6], edge_q[c][5], 3'b000, edge_q[c][0], edge_q[c][0]};
    // rising edge always, falling edge when selected
    assign edg0 = (s0 & ~prv0_q[c]) | (~s0 & prv0_q[c] & ies0);
    assign edg1 = (s1 & ~prv1_q[c]) | (~s1 & prv1_q[c] & ies1);
    // unmasked pending of this channel
    assign chan_act[c] = !glb_masked && (|(pend0_q[c] & ~mask0_q[c]) || |(pend1_q[c] & ~mask1_q[c])
                         || |(pend2_q[c] & ~mask2_q[c]));

    // next values of the channel registers
    always_comb
    begin
      lia_pkg::lia_byte_type clr0;
      lia_pkg::lia_byte_type clr1;
      lia_pkg::lia_byte_type clr2;
      clr0 = (wr_ch[c] && idx == `LIA_IDX_PEND0) ? wdat : 8'h00;
      clr1 = (wr_ch[c] && idx == `LIA_IDX_PEND1) ? wdat : 8'h00;
      clr2 = (wr_ch[c] && idx == `LIA_IDX_PEND2) ? wdat : 8'h00;
      prv0_d[c]  = s0;
      prv1_d[c]  = s1;
      edge_d[c]  = edge_q[c];
      mask0_d[c] = mask0_q[c];
      mask1_d[c] = mask1_q[c];
      mask2_d[c] = mask2_q[c];
      std_d[c]   = std_q[c];
      srst_d[c]  = busy[c] ? srst_q[c] - 6'h01 : srst_q[c];
      // set wins over a clearing write in the same cycle
      pend0_d[c] = (pend0_q[c] & ~clr0) | {pend0_evt_i[c*3 +: 3], edg0};
      pend1_d[c] = (pend1_q[c] & ~clr1) | edg1;
      pend2_d[c] = (pend2_q[c] & ~clr2) | {2'b00, pend2_evt_i[c*6 +: 6]};
      if (wr_ch[c] && !busy[c])
      begin
        unique case (idx)
          `LIA_IDX_EDGE:  edge_d[c]  = wdat;
          `LIA_IDX_MASK0: mask0_d[c] = wdat;
          `LIA_IDX_MASK1: mask1_d[c] = wdat & `LIA_PEND1_USED;
          `LIA_IDX_MASK2: mask2_d[c] = wdat & `LIA_PEND2_USED;
          `LIA_IDX_CHCF:
          begin
            std_d[c] = wdat[`LIA_CHCF_STD];
            if (wdat[`LIA_CHCF_SRST])
              srst_d[c] = 6'(`LIA_SRST_CYCLES);
          end
          default: ;
        endcase
      end
      // channel soft reset holds the channel at defaults, line standard kept
      if (busy[c])
      begin
        edge_d[c]  = `LIA_EDGE_RST;
        mask0_d[c] = `LIA_MASK_RST;
        mask1_d[c] = `LIA_MASK_RST & `LIA_PEND1_USED;
        mask2_d[c] = `LIA_MASK_RST & `LIA_PEND2_USED;
        pend0_d[c] = 8'h00;
        pend1_d[c] = 8'h00;
        pend2_d[c] = 8'h00;
        prv0_d[c]  = 5'h00;
        prv1_d[c]  = 8'h00;
      end
    end

    // channel registers
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        edge_q[c]  <= `LIA_EDGE_RST;
        mask0_q[c] <= `LIA_MASK_RST;
        mask1_q[c] <= `LIA_MASK_RST & `LIA_PEND1_USED;
        mask2_q[c] <= `LIA_MASK_RST & `LIA_PEND2_USED;
        pend0_q[c] <= 8'h00;
        pend1_q[c] <= 8'h00;
        pend2_q[c] <= 8'h00;
        prv0_q[c]  <= 5'h00;
        prv1_q[c]  <= 8'h00;
        srst_q[c]  <= 6'h00;
        std_q[c]   <= 1'b0;
      end
      else
      begin
        edge_q[c]  <= edge_d[c];
        mask0_q[c] <= mask0_d[c];
        mask1_q[c] <= mask1_d[c];
        mask2_q[c] <= mask2_d[c];
        pend0_q[c] <= pend0_d[c];
        pend1_q[c] <= pend1_d[c];
        pend2_q[c] <= pend2_d[c];
        prv0_q[c]  <= prv0_d[c];
        prv1_q[c]  <= prv1_d[c];
        srst_q[c]  <= srst_d[c];
        std_q[c]   <= std_d[c];
      end
    end
  end

  // one second divider and global registers, next values
  always_comb
  begin
    tick       = (tick_cnt_q == 26'(SECOND_CYCLES - 1));
    tick_cnt_d = tick ? 26'h000_0000 : tick_cnt_q + 26'h000_0001;
    gcf_d      = gcf_q;
    tmr_pend_d = tmr_pend_q | tick;
    if (wr_hit && glb_ok && idx == 4'(`LIA_OFS_GCF))
      gcf_d = wdat & `LIA_GCF_RST;
    if (wr_hit && glb_ok && idx == 4'(`LIA_OFS_TIMER) && wdat[`LIA_TIMER_PEND] && !tick)
      tmr_pend_d = 1'b0;
    any_act = (|chan_act) || (tmr_pend_q && !gcf_q[`LIA_GCF_TICK_MASK] && !glb_masked);
  end

  // read mux and ack
  always_comb
  begin
    rdat_d = 32'h0000_0000;
    ack_d  = req;
    if (req && !wb_we_i && glb_ok)
    begin
      unique case (idx)
        4'(`LIA_OFS_GCF):   rdat_d[7:0] = gcf_q;
        4'(`LIA_OFS_TIMER): rdat_d[0]   = tmr_pend_q;
        4'(`LIA_OFS_SUM0):  rdat_d[7:0] = sum_q[7:0];
        4'(`LIA_OFS_SUM1):  rdat_d[7:0] = sum_q[15:8];
        4'(`LIA_OFS_SUM2):  rdat_d[0]   = sum_q[16];
        default:            rdat_d      = 32'h0000_0000;
      endcase
    end
    else if (req && !wb_we_i && ch_ok)
    begin
      unique case (idx)
        `LIA_IDX_LIVE_STATUS_REG0: rdat_d[4:0] = live_status_reg0_i[ch_sel*5 +: 5];
        `LIA_IDX_LIVE_STATUS_REG1: rdat_d[7:0] = live_status_reg1_i[ch_sel*8 +: 8] & `LIA_PEND1_USED;
        `LIA_IDX_EDGE:  rdat_d[7:0] = edge_q[ch_sel];
        `LIA_IDX_PEND0: rdat_d[7:0] = pend0_q[ch_sel];
        `LIA_IDX_PEND1: rdat_d[7:0] = pend1_q[ch_sel];
        `LIA_IDX_PEND2: rdat_d[7:0] = pend2_q[ch_sel];
        `LIA_IDX_MASK0: rdat_d[7:0] = mask0_q[ch_sel];
        `LIA_IDX_MASK1: rdat_d[7:0] = mask1_q[ch_sel];
        `LIA_IDX_MASK2: rdat_d[7:0] = mask2_q[ch_sel];
        `LIA_IDX_CHCF:  rdat_d[1:0] = {busy[ch_sel], std_q[ch_sel]};
        default:        rdat_d      = 32'h0000_0000;
      endcase
    end
  end

  // global registers, bus answer and registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gcf_q      <= `LIA_GCF_RST;
      tmr_pend_q <= 1'b0;
      tick_cnt_q <= 26'h000_0000;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0000_0000;
      sum_q      <= '0;
      irq_q      <= 1'b0;
    end
    else
    begin
      gcf_q      <= gcf_d;
      tmr_pend_q <= tmr_pend_d;
      tick_cnt_q <= tick_cnt_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
      sum_q      <= chan_act;
      irq_q      <= any_act;
    end
  end

  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = rdat_q;
  assign channel_summary_o = sum_q;
  assign line_standard_o   = std_q;
  assign int_n_o           = 1'b0;
  assign int_n_oe_o        = irq_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_single;
    ack_q |=> !ack_q;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

  property p_pin_on;
    tmr_pend_q && !gcf_q[`LIA_GCF_TICK_MASK] && !glb_masked |=> int_n_oe_o;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("interrupt pin not driven");

  property p_sum_pin;
    (|channel_summary_o) |-> int_n_oe_o;
  endproperty
  a_sum_pin: assert property (p_sum_pin) else $error("summary set with pin idle");

  property p_pin_off;
    $fell(int_n_oe_o) |-> channel_summary_o == '0;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin released with pending");

  property p_clear;
    wr_ch[16] && idx == `LIA_IDX_PEND0 && wdat[5] && !pend0_evt_i[48] |=> !pend0_q[16][5];
  endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");

  property p_set_wins;
    wr_ch[16] && idx == `LIA_IDX_PEND0 && wdat[5] && pend0_evt_i[48] && !busy[16] |=> pend0_q[16][5];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  property p_rise;
    !busy[3] && live_status_reg0_i[15] && !prv0_q[3][0] |=> pend0_q[3][0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising status missed");

  property p_fall_pair;
    !busy[3] && !live_status_reg0_i[16] && prv0_q[3][1] && edge_q[3][1] |=> pend0_q[3][1];
  endproperty
  a_fall_pair: assert property (p_fall_pair) else $error("shared edge select ignored");

  property p_srst_len;
    $rose(busy[3]) |-> busy[3][*8] ##[1:40] !busy[3];
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("channel reset length wrong");

  property p_srst_mask;
    $fell(busy[3]) |-> mask0_q[3] == `LIA_MASK_RST && std_q[3] == $past(std_q[3], 2);
  endproperty
  a_srst_mask: assert property (p_srst_mask) else $error("channel reset left sources open");

  property p_tick;
    tick |=> tmr_pend_q;
  endproperty
  a_tick: assert property (p_tick) else $error("second tick not pended");

  property p_summary;
    !glb_masked && |(pend0_q[3] & ~mask0_q[3]) |=> channel_summary_o[3];
  endproperty
  a_summary: assert property (p_summary) else $error("summary not set");

  c_irq:   cover property ($rose(int_n_oe_o));
  c_srst:  cover property ($fell(busy[3]));
  c_clear: cover property ($fell(int_n_oe_o));
endmodule

// [src/lia_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz device clock and a 32-bit classic wishbone slave
`ifndef LIA_REGS_SVH
`define LIA_REGS_SVH

// channel count and address layout
`define LIA_NUM_CH          17
`define LIA_CH_FIRST_SLOT   5'h4
`define LIA_ADR_TOP_ZERO    5'h00
// global registers, word indices
`define LIA_OFS_GCF         6'h00
`define LIA_OFS_TIMER       6'h01
`define LIA_OFS_SUM0        6'h02
`define LIA_OFS_SUM1        6'h03
`define LIA_OFS_SUM2        6'h04
// per-channel register word indices
`define LIA_IDX_LIVE_STATUS_REG0       4'h0
`define LIA_IDX_LIVE_STATUS_REG1       4'h1
`define LIA_IDX_EDGE        4'h2
`define LIA_IDX_PEND0       4'h3
`define LIA_IDX_PEND1       4'h4
`define LIA_IDX_PEND2       4'h5
`define LIA_IDX_MASK0       4'h6
`define LIA_IDX_MASK1       4'h7
`define LIA_IDX_MASK2       4'h8
`define LIA_IDX_CHCF        4'h9
// field positions
`define LIA_GCF_TICK_MASK   0
`define LIA_GCF_GLB_MASK    1
`define LIA_TIMER_PEND      0
`define LIA_CHCF_STD        0
`define LIA_CHCF_SRST       1
// reset values and used-bit masks
`define LIA_GCF_RST         8'h03
`define LIA_MASK_RST        8'hFF
`define LIA_EDGE_RST        8'h00
`define LIA_PEND1_USED      8'hE3
`define LIA_PEND2_USED      8'h3F
// timing
`define LIA_CLK_PERIOD_NS   25
`define LIA_SECOND_US       1000000
`define LIA_SECOND_CYCLES   ((`LIA_SECOND_US * 1000) / `LIA_CLK_PERIOD_NS)
`define LIA_SRST_NS         1000
`define LIA_SRST_CYCLES     (`LIA_SRST_NS / `LIA_CLK_PERIOD_NS)

`endif

// [src/lia_pkg.sv]
// types shared by the interrupt aggregator
// assumes lia_regs.svh is compiled alongside
package lia_pkg;
  typedef logic [7:0]  lia_byte_type;
  typedef logic [4:0]  lia_slot_type;
  typedef logic [5:0]  lia_srst_cnt_type;
  typedef logic [25:0] lia_tick_cnt_type;
endpackage

// [dv/lia_host_model.sv]
// host model: classic wishbone master that services the aggregator
// assumes one clock shared with the aggregator; pin level is resolved in tb
`timescale 1ns/1ps
module lia_host_model (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [15:0]      wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  // bus hang flag
  output logic             hung_o
);
  // bus idle at time zero
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 16'h0000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
    hung_o   = 1'b0;
  end

  // one classic cycle, held until ack is sampled high or 20 clocks pass
  task automatic xfer(input logic we, input logic [15:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= wd;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_i !== 1'b1 && n < 20);
    rd = wb_dat_i;
    if (wb_ack_i !== 1'b1)
      hung_o <= 1'b1;
    // released lines stop showing the old request
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~wd;
  endtask

  // acknowledge by writing ones to pending flags
  task automatic ack_irq(input logic [15:0] adr, input logic [7:0] bits);
    logic [31:0] rd;
    xfer(1'b1, adr, {24'h00_0000, bits}, rd);
  endtask
endmodule

// [dv/tb.sv]
// testbench for the interrupt aggregator, driven through a host model
// assumes the 40 MHz clock and a short one-second count for simulation
`timescale 1ns/1ps
`include "lia_regs.svh"
module tb;
  localparam int unsigned TICK = 50;
  // stimulus and observed nets
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic [`LIA_NUM_CH*5-1:0]  live_status_reg0 = '0;
  logic [`LIA_NUM_CH*8-1:0]  live_status_reg1 = '0;
  logic [`LIA_NUM_CH*3-1:0]  ev0   = '0;
  logic [`LIA_NUM_CH*6-1:0]  ev2   = '0;
  logic                      cyc, stb, we, ack, int_n, int_oe, hung;
  logic [15:0]               adr;
  logic [3:0]                sel;
  logic [31:0]               dmo, dso, rd;
  logic [`LIA_NUM_CH-1:0]    sum, std;
  int                        n_fail = 0;
  int                        num_checks = 0;
  // open-drain pin with pull-up
  wire                       int_pin = int_oe ? int_n : 1'b1;

  // clock
  always #12.5 clk_i = ~clk_i;

  lia_intr_agg #(.SECOND_CYCLES(TICK)) lia_intr_agg_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dmo), .wb_dat_o(dso), .wb_ack_o(ack),
    .live_status_reg0_i(live_status_reg0), .live_status_reg1_i(live_status_reg1), .pend0_evt_i(ev0), .pend2_evt_i(ev2),
    .int_n_o(int_n), .int_n_oe_o(int_oe), .channel_summary_o(sum), .line_standard_o(std));

  lia_host_model lia_host_model_i (
    .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(dmo), .wb_ack_i(ack), .wb_dat_i(dso), .hung_o(hung));

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // value compare
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // register read and compare, register write
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    lia_host_model_i.xfer(1'b0, a, 32'h0000_0000, rd);
    chk($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    lia_host_model_i.xfer(1'b1, a, {24'h00_0000, d}, rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // a hung bus ends the run
  always @(posedge clk_i)
    if (hung === 1'b1)
    begin
      n_fail++;
      complete_run();
    end

  // main sequence
  initial
  begin
    wt(4);
    rst_i <= 1'b0;
    rchk(16'h0000, 32'h0000_0003);
    rchk(16'h01D8, 32'h0000_00FF);
    rchk(16'h01DC, 32'h0000_00E3);
    rchk(16'h01E0, 32'h0000_003F);
    rchk(16'h0FFC, 32'h0000_0000);
    chk("pin idle", 32'h1, {31'h0, int_pin});
    $display("test reset done");
    // rising edge on channel 3 line loss
    wr(16'h0000, 8'h01);
    live_status_reg0[15] <= 1'b1;
    wt(3);
    rchk(16'h01CC, 32'h0000_0001);
    chk("pin masked", 32'h1, {31'h0, int_pin});
    wr(16'h01D8, 8'hFE);
    wt(3);
    chk("pin", 32'h0, {31'h0, int_pin});
    chk("summary", 32'h0000_0008, {15'h0000, sum});
    rchk(16'h0008, 32'h0000_0008);
    wr(16'h01CC, 8'h00);
    rchk(16'h01CC, 32'h0000_0001);
    lia_host_model_i.ack_irq(16'h01CC, 8'h01);
    wt(2);
    chk("pin cleared", 32'h1, {31'h0, int_pin});
    live_status_reg0[15] <= 1'b0;
    wt(3);
    rchk(16'h01CC, 32'h0000_0000);
    // both edges through the shared loss select
    wr(16'h01C8, 8'h02);
    live_status_reg0[16:15] <= 2'b11;
    wt(3);
    lia_host_model_i.ack_irq(16'h01CC, 8'h03);
    live_status_reg0[16:15] <= 2'b00;
    wt(3);
    rchk(16'h01CC, 32'h0000_0003);
    $display("test edges done");
    // direct events and pattern status on channel 16
    ev0[48] <= 1'b1;
    ev2[97:96] <= 2'b11;
    live_status_reg1[133] <= 1'b1;
    live_status_reg1[129:128] <= 2'b11;
    wt(1);
    ev0[48] <= 1'b0;
    ev2[97:96] <= 2'b00;
    wt(3);
    rchk(16'h050C, 32'h0000_0020);
    rchk(16'h0510, 32'h0000_0023);
    rchk(16'h0514, 32'h0000_0003);
    chk("summary masked", 32'h0000_0008, {15'h0000, sum});
    // clearing write and a new event land in one cycle: the event wins
    fork
      lia_host_model_i.ack_irq(16'h050C, 8'h20);
      begin
        @(posedge clk_i);
        ev0[48] <= 1'b1;
        @(posedge clk_i);
        ev0[48] <= 1'b0;
      end
    join
    rchk(16'h050C, 32'h0000_0020);
    lia_host_model_i.ack_irq(16'h050C, 8'h20);
    rchk(16'h050C, 32'h0000_0000);
    wr(16'h0520, 8'h3C);
    wt(3);
    rchk(16'h0010, 32'h0000_0001);
    lia_host_model_i.ack_irq(16'h01CC, 8'h03);
    wt(2);
    chk("pin other channel", 32'h0, {31'h0, int_pin});
    lia_host_model_i.ack_irq(16'h0514, 8'h01);
    wt(2);
    chk("summary held", 32'h0001_0000, {15'h0000, sum});
    lia_host_model_i.ack_irq(16'h0514, 8'h02);
    wt(2);
    chk("summary released", 32'h0, {15'h0000, sum});
    chk("pin released", 32'h1, {31'h0, int_pin});
    $display("test events done");
    // one-second tick
    rchk(16'h0004, 32'h0000_0001);
    wr(16'h0000, 8'h00);
    wt(3);
    chk("pin tick", 32'h0, {31'h0, int_pin});
    wr(16'h0000, 8'h02);
    wt(3);
    chk("pin global mask", 32'h1, {31'h0, int_pin});
    lia_host_model_i.ack_irq(16'h0004, 8'h01);
    wr(16'h0000, 8'h01);
    $display("test tick done");
    // channel soft reset
    wr(16'h01E4, 8'h01);
    wr(16'h01E4, 8'h03);
    rchk(16'h01E4, 32'h0000_0003);
    wt(45);
    rchk(16'h01E4, 32'h0000_0001);
    rchk(16'h01D8, 32'h0000_00FF);
    rchk(16'h01C8, 32'h0000_0000);
    rchk(16'h0520, 32'h0000_003C);
    chk("line standard", 32'h0000_0008, {15'h0000, std});
    $display("test soft reset done");
    complete_run();
  end
endmodule
